//--- inc/sdram_cfg_pkg.sv
package sdram_cfg_pkg;
    // register byte offsets inside the controller window
    localparam logic [15:0] OFS_CTRL_ONE = 16'h8400;
    localparam logic [15:0] OFS_CTRL_TWO = 16'h8404;
    localparam logic [15:0] OFS_SYNC_TIM = 16'h8408;
    localparam logic [15:0] OFS_ARB_REQ  = 16'h840c;
    localparam logic [15:0] OFS_STATUS   = 16'h8410;
    // reset values
    localparam logic [31:0] RST_CTRL_ONE = 32'h00000040;
    localparam logic [31:0] RST_CTRL_TWO = 32'h00000801;
    localparam logic [31:0] RST_SYNC_TIM = 32'h00000000;
    // control one field positions
    localparam int B_PROG     = 0;
    localparam int B_REMAP    = 2;
    localparam int B_ARB      = 3;
    localparam int B_TESTRF   = 4;
    localparam int B_SETUP    = 5;
    localparam int B_STAG_LO  = 6;
    localparam int B_STAG_HI  = 7;
    // control two field positions
    localparam int B_CLK0_MSK = 6;
    localparam int B_CLK3_MSK = 9;
    localparam int B_FB_MSK   = 10;
    localparam logic [31:0] WMASK_ONE = 32'h000000fd;
    localparam logic [31:0] WMASK_TWO = 32'h00003fff;
    // latency field in the sync timing register
    localparam int B_LAT_LO   = 0;
    localparam int B_LAT_HI   = 2;
    // management window remap
    localparam logic [23:0] MGMT_WIN_BASE = 24'h400000;
    localparam logic [23:0] MGMT_WIN_LAST = 24'h41ffff;
    localparam logic [23:0] REMAP_BASE    = 24'h0a0000;
    // stagger gaps in core clocks
    localparam logic [2:0] GAP_00 = 3'h0;
    localparam logic [2:0] GAP_01 = 3'h1;
    localparam logic [2:0] GAP_10 = 3'h2;
    localparam logic [2:0] GAP_11 = 3'h4;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sdram_cfg_pkg

//--- logic/sdram_ctrl_config.sv
`timescale 1ns/10ps
`default_nettype none

module sdram_ctrl_config #(
    parameter int ADDR_W = 16
) (
    // system
    input  wire logic              i_clock,
    input  wire logic              i_sys_rst,
    // memory side clock
    input  wire logic              i_mem_clock,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output var  logic              o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output var  logic              o_wready,
    output var  logic [1:0]        o_bresp,
    output var  logic              o_bvalid,
    input  wire logic              i_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output var  logic              o_arready,
    output var  logic [31:0]       o_rdata,
    output var  logic [1:0]        o_rresp,
    output var  logic              o_rvalid,
    input  wire logic              i_rready,
    // address remap path
    input  wire logic [23:0]       i_mem_addr,
    output var  logic [23:0]       o_mem_addr,
    // sdram command side
    output var  logic              o_addr_drive,
    output var  logic              o_chip_sel,
    output var  logic              o_refresh_cmd,
    output var  logic              o_mode_set_cmd,
    output var  logic [2:0]        o_mode_latency,
    input  wire logic              i_access_req,
    input  wire logic              i_banks_precharged,
    input  wire logic              i_refresh_due,
    // memory clocks
    output var  logic              o_feedback_mem_clock,
    output var  logic [3:0]        o_mem_clk
);
    initial begin
        if (ADDR_W < 16) begin
            $error("address too narrow for register map");
        end
    end

    logic [31:0] ctrl_one;
    logic [31:0] ctrl_two;
    logic [31:0] sync_tim;
    logic [3:0]  arb_req;
    logic [1:0]  arb_grant;

    // ---- axi write: address and data taken in either order
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    wire do_write = aw_held && w_held && !o_bvalid;
    wire [15:0] wofs = aw_addr[15:0];
    wire wr_one = wofs == sdram_cfg_pkg::OFS_CTRL_ONE;
    wire wr_two = wofs == sdram_cfg_pkg::OFS_CTRL_TWO;
    wire wr_syn = wofs == sdram_cfg_pkg::OFS_SYNC_TIM;
    wire wr_arb = wofs == sdram_cfg_pkg::OFS_ARB_REQ;
    wire wr_hit = wr_one || wr_two || wr_syn || wr_arb;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st,
                                          input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & wm;
        return (old & ~m) | (nw & m);
    endfunction : merge

    // address and data hold registers
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // ready flags and write response
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= sdram_cfg_pkg::RESP_OKAY;
        end else begin
            o_awready <= !aw_held && !(i_awvalid && o_awready);
            o_wready  <= !w_held && !(i_wvalid && o_wready);
            if (do_write) begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_hit ? sdram_cfg_pkg::RESP_OKAY
                                   : sdram_cfg_pkg::RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // register file; reserved bits of the two control registers are never stored
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ctrl_one <= sdram_cfg_pkg::RST_CTRL_ONE;
            ctrl_two <= sdram_cfg_pkg::RST_CTRL_TWO;
            sync_tim <= sdram_cfg_pkg::RST_SYNC_TIM;
            arb_req  <= 4'h0;
        end else if (do_write) begin
            if (wr_one) begin
                ctrl_one <= merge(ctrl_one, w_data, w_strb,
                                  sdram_cfg_pkg::WMASK_ONE);
            end
            if (wr_two) begin
                ctrl_two <= merge(ctrl_two, w_data, w_strb,
                                  sdram_cfg_pkg::WMASK_TWO);
            end
            if (wr_syn) begin
                sync_tim <= merge(sync_tim, w_data, w_strb, 32'hffffffff);
            end
            if (wr_arb && w_strb[0]) begin
                arb_req <= w_data[3:0];
            end
        end
    end

    // ---- axi read
    logic [31:0] status;
    wire [15:0] rofs = i_araddr[15:0];
    wire rd_hit = rofs == sdram_cfg_pkg::OFS_CTRL_ONE
               || rofs == sdram_cfg_pkg::OFS_CTRL_TWO
               || rofs == sdram_cfg_pkg::OFS_SYNC_TIM
               || rofs == sdram_cfg_pkg::OFS_ARB_REQ
               || rofs == sdram_cfg_pkg::OFS_STATUS;
    wire [31:0] rd_mux =
        rofs == sdram_cfg_pkg::OFS_CTRL_ONE ? ctrl_one :
        rofs == sdram_cfg_pkg::OFS_CTRL_TWO ? ctrl_two :
        rofs == sdram_cfg_pkg::OFS_SYNC_TIM ? sync_tim :
        rofs == sdram_cfg_pkg::OFS_ARB_REQ  ? {28'h0, arb_req} :
        rofs == sdram_cfg_pkg::OFS_STATUS   ? status : 32'h0;

    // one read at a time, answered the cycle after acceptance
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0;
            o_rresp   <= sdram_cfg_pkg::RESP_OKAY;
        end else begin
            o_arready <= !o_rvalid && !(i_arvalid && o_arready);
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_mux;
                o_rresp  <= rd_hit ? sdram_cfg_pkg::RESP_OKAY
                                   : sdram_cfg_pkg::RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ---- internal bus arbiter: 0 hp display, 1 cpu, 2 gfx, 3 display
    logic [1:0] rr_last;
    wire rr_mode = ctrl_one[sdram_cfg_pkg::B_ARB];
    function automatic logic [1:0] rr_pick(input logic [2:0] rq,
                                           input logic [1:0] last);
        logic [1:0] pick;
        pick = 2'd0;
        for (int k = 3; k >= 1; k--) begin
            if (rq[(int'(last) + k) % 3]) begin
                pick = 2'((int'(last) + k) % 3 + 1);
            end
        end
        return pick;
    endfunction : rr_pick
    wire [1:0] fixed_pick = arb_req[1] ? 2'd1 : arb_req[2] ? 2'd2 :
                            arb_req[3] ? 2'd3 : 2'd0;
    wire [1:0] low_pick = rr_mode ? rr_pick(arb_req[3:1], rr_last)
                                  : fixed_pick;
    wire [1:0] next_grant = arb_req[0] ? 2'd0 : low_pick;
    wire       any_req    = |arb_req;

    // grant register; round robin pointer moves only on a shared grant
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            arb_grant <= 2'd0;
            rr_last   <= 2'd0;
        end else begin
            arb_grant <= next_grant;
            if (any_req && !arb_req[0]) begin
                rr_last <= 2'(next_grant - 2'd1);
            end
        end
    end

    // ---- management window remap
    wire in_win = i_mem_addr >= sdram_cfg_pkg::MGMT_WIN_BASE
               && i_mem_addr <= sdram_cfg_pkg::MGMT_WIN_LAST;
    wire [23:0] next_mem_addr =
        (ctrl_one[sdram_cfg_pkg::B_REMAP] && in_win)
        ? sdram_cfg_pkg::REMAP_BASE
          + (i_mem_addr - sdram_cfg_pkg::MGMT_WIN_BASE)
        : i_mem_addr;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_mem_addr <= 24'h0;
        end else begin
            o_mem_addr <= next_mem_addr;
        end
    end

    // ---- mode program trigger: registered copy finds the rise
    logic prog_last;
    logic prog_pend;
    logic rf_busy;
    wire  prog_rise = ctrl_one[sdram_cfg_pkg::B_PROG] && !prog_last;
    // a burst still in flight counts as a pending refresh
    wire  prog_go   = prog_pend && i_banks_precharged && !rf_busy
                   && !i_refresh_due && !o_refresh_cmd;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            prog_last      <= 1'b0;
            prog_pend      <= 1'b0;
            o_mode_set_cmd <= 1'b0;
            o_mode_latency <= 3'h0;
        end else begin
            prog_last      <= ctrl_one[sdram_cfg_pkg::B_PROG];
            prog_pend      <= prog_rise || (prog_pend && !prog_go);
            o_mode_set_cmd <= prog_go;
            if (prog_go) begin
                o_mode_latency <= sync_tim[sdram_cfg_pkg::B_LAT_HI:
                                           sdram_cfg_pkg::B_LAT_LO];
            end
        end
    end

    // ---- refresh: test bit and due input, banks spaced by stagger gap
    logic [2:0] gap_cnt;
    logic [1:0] bank_cnt;
    logic       test_last;
    wire [1:0] stag = ctrl_one[sdram_cfg_pkg::B_STAG_HI:
                               sdram_cfg_pkg::B_STAG_LO];
    wire [2:0] gap = stag == 2'b00 ? sdram_cfg_pkg::GAP_00 :
                     stag == 2'b01 ? sdram_cfg_pkg::GAP_01 :
                     stag == 2'b10 ? sdram_cfg_pkg::GAP_10 :
                                     sdram_cfg_pkg::GAP_11;
    wire test_rise = ctrl_one[sdram_cfg_pkg::B_TESTRF] && !test_last;
    wire rf_start  = !rf_busy && (test_rise || i_refresh_due);
    // zero gap means all four banks refresh together in one command
    wire rf_issue  = rf_busy && gap_cnt == 3'h0;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rf_busy       <= 1'b0;
            gap_cnt       <= 3'h0;
            bank_cnt      <= 2'd0;
            test_last     <= 1'b0;
            o_refresh_cmd <= 1'b0;
        end else begin
            test_last     <= ctrl_one[sdram_cfg_pkg::B_TESTRF];
            o_refresh_cmd <= rf_issue;
            if (rf_start) begin
                rf_busy  <= 1'b1;
                gap_cnt  <= 3'h0;
                bank_cnt <= 2'd0;
            end else if (rf_issue) begin
                gap_cnt  <= gap;
                bank_cnt <= 2'(bank_cnt + 2'd1);
                rf_busy  <= (gap != 3'h0) && (bank_cnt != 2'd3);
            end else if (rf_busy) begin
                gap_cnt <= 3'(gap_cnt - 3'h1);
            end
        end
    end

    // ---- command timing: address first, chip select one clock later
    logic setup_wait;
    wire  setup_on = ctrl_one[sdram_cfg_pkg::B_SETUP];
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_addr_drive <= 1'b0;
            o_chip_sel   <= 1'b0;
            setup_wait   <= 1'b0;
        end else begin
            o_addr_drive <= i_access_req;
            setup_wait   <= i_access_req && !o_addr_drive;
            o_chip_sel   <= setup_on ? (i_access_req && o_addr_drive)
                                     : i_access_req;
        end
    end

    assign status = {26'h0, prog_pend, rf_busy, arb_grant, rr_mode,
                     setup_wait};

    // ---- memory clock domain: reset and masks cross through two flops
    logic       mem_rst_s1;
    logic       mem_rst_s2;
    logic [4:0] msk_s1;
    logic [4:0] msk_s2;
    wire  [4:0] msk_src = {ctrl_two[sdram_cfg_pkg::B_FB_MSK],
                           ctrl_two[sdram_cfg_pkg::B_CLK3_MSK:
                                    sdram_cfg_pkg::B_CLK0_MSK]};
    logic       mem_phase;
    // without a reset the divider would stay unknown; a reset pulse
    // shorter than one link period may be missed here
    always_ff @(posedge i_mem_clock) begin
        mem_rst_s1 <= i_sys_rst;
        mem_rst_s2 <= mem_rst_s1;
        msk_s1     <= msk_src;
        msk_s2     <= msk_s1;
        if (mem_rst_s2) begin
            mem_phase            <= 1'b0;
            o_feedback_mem_clock <= 1'b0;
            o_mem_clk            <= 4'h0;
        end else begin
            mem_phase <= !mem_phase;
            // outputs toggle at half the link rate while unmasked
            o_feedback_mem_clock <= !msk_s2[4] && mem_phase;
            o_mem_clk            <= ~msk_s2[3:0] & {4{mem_phase}};
        end
    end

    // assertions
    property p_reset_two;
        @(posedge i_clock) $fell(i_sys_rst) |-> ctrl_two == 32'h00000801;
    endproperty
    a_reset_two: assert property (p_reset_two)
        else $error("control two reset value wrong");

    property p_hp_wins;
        @(posedge i_clock) disable iff (i_sys_rst)
        arb_req[0] |=> arb_grant == 2'd0;
    endproperty
    a_hp_wins: assert property (p_hp_wins)
        else $error("high priority display not granted");

    property p_fixed_cpu;
        @(posedge i_clock) disable iff (i_sys_rst)
        (!rr_mode && !arb_req[0] && arb_req[1]) |=> arb_grant == 2'd1;
    endproperty
    a_fixed_cpu: assert property (p_fixed_cpu)
        else $error("processor lost fixed arbitration");

    property p_rr_rotate;
        @(posedge i_clock) disable iff (i_sys_rst)
        (rr_mode && arb_req == 4'he && rr_last == 2'd0) |=> arb_grant == 2'd2;
    endproperty
    a_rr_rotate: assert property (p_rr_rotate)
        else $error("round robin did not rotate");

    property p_remap;
        @(posedge i_clock) disable iff (i_sys_rst)
        (ctrl_one[sdram_cfg_pkg::B_REMAP] && i_mem_addr == 24'h400010)
            |=> o_mem_addr == 24'h0a0010;
    endproperty
    a_remap: assert property (p_remap)
        else $error("window not remapped");

    property p_mode_once;
        @(posedge i_clock) disable iff (i_sys_rst)
        o_mode_set_cmd |=> !o_mode_set_cmd;
    endproperty
    a_mode_once: assert property (p_mode_once)
        else $error("mode set repeated without new edge");

    property p_mode_safe;
        @(posedge i_clock) disable iff (i_sys_rst)
        o_mode_set_cmd |-> $past(i_banks_precharged) && !$past(i_refresh_due);
    endproperty
    a_mode_safe: assert property (p_mode_safe)
        else $error("mode set while banks busy");

    property p_setup;
        @(posedge i_clock) disable iff (i_sys_rst)
        (setup_on && $past(setup_on) && $rose(o_chip_sel))
            |-> $past(o_addr_drive);
    endproperty
    a_setup: assert property (p_setup)
        else $error("chip select without address setup");

    property p_test_refresh;
        @(posedge i_clock) disable iff (i_sys_rst)
        (test_rise && !rf_busy) |-> ##[1:3] o_refresh_cmd;
    endproperty
    a_test_refresh: assert property (p_test_refresh)
        else $error("test refresh produced no command");
endmodule : sdram_ctrl_config

`default_nettype wire

//--- test/sdram_model.sv
`timescale 1ns/10ps
`default_nettype none

// behavioural memory device: logs commands and clock activity
module sdram_model (
    // core side
    input  wire logic        i_clock,
    input  wire logic        i_refresh_cmd,
    input  wire logic        i_mode_set_cmd,
    input  wire logic [2:0]  i_mode_latency,
    input  wire logic        i_busy,
    output var  logic        o_banks_precharged,
    // memory clocks
    input  wire logic        i_fb_clk,
    input  wire logic [3:0]  i_mem_clk,
    // observed counts
    output var  logic [15:0] o_n_ref,
    output var  logic [15:0] o_ref_gap,
    output var  logic [15:0] o_n_mode,
    output var  logic [2:0]  o_lat,
    output var  logic [15:0] o_clk_cnt [5]
);
    logic [15:0] cyc;
    logic [15:0] last;

    // banks stay open while a burst is in flight
    assign o_banks_precharged = !i_busy;

    // counters start clean so deltas are meaningful
    initial begin
        cyc = '0;
        last = '0;
        o_n_ref = '0;
        o_ref_gap = '0;
        o_n_mode = '0;
        o_lat = '0;
        foreach (o_clk_cnt[k]) o_clk_cnt[k] = '0;
    end

    // gap is core cycles between two refresh commands
    always @(posedge i_clock) begin
        cyc <= cyc + 16'h0001;
        if (i_refresh_cmd) begin
            o_n_ref <= o_n_ref + 16'h0001;
            o_ref_gap <= cyc - last;
            last <= cyc;
        end
        if (i_mode_set_cmd) begin
            o_n_mode <= o_n_mode + 16'h0001;
            o_lat <= i_mode_latency;
        end
    end

    // edge counts tell a running clock from a held one
    always @(posedge i_fb_clk) o_clk_cnt[4] <= o_clk_cnt[4] + 16'h0001;
    for (genvar k = 0; k < 4; k++) begin : g_cnt
        always @(posedge i_mem_clk[k]) o_clk_cnt[k] <= o_clk_cnt[k] + 16'h0001;
    end
endmodule : sdram_model

`default_nettype wire

//--- test/sdram_ctrl_config_bits_test.sv
`timescale 1ns/10ps
`default_nettype none

module sdram_ctrl_config_bits_test;
    typedef struct packed {
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] rexp;
        logic [1:0]  resp;
    } row_t;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_mem_clock = 1'b0;
    logic [15:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0]  wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, busy = 0, req = 0, due = 0;
    logic [1:0]  bresp, rresp, rs;
    logic [23:0] mem_addr = '0, o_mem_addr;
    logic addr_drive, chip_sel, ref_cmd, mode_cmd, prech, fb_clk;
    logic [2:0]  lat, m_lat;
    logic [3:0]  mem_clk;
    logic [15:0] n_ref, ref_gap, n_mode, cnt [5], snap [5], base;
    int num_errors = 0, n_checks = 0;
    row_t rows [5] = '{
        '{16'h8404, 32'h00003fff, 32'h00003fff, 2'h0},
        '{16'h8404, 32'h00000801, 32'h00000801, 2'h0},
        '{16'h8400, 32'hffffff00, 32'h00000000, 2'h0},
        '{16'h8408, 32'h00000005, 32'h00000005, 2'h0},
        '{16'h8420, 32'h0000dead, 32'h00000000, 2'h2}};

    // core clock 20 ns, link clock 48 ns with its own phase
    always #10 i_clock = ~i_clock;
    initial #7 forever #24 i_mem_clock = ~i_mem_clock;

    sdram_ctrl_config sdram_ctrl_config_i (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_mem_clock(i_mem_clock),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .i_mem_addr(mem_addr),
        .o_mem_addr(o_mem_addr), .o_addr_drive(addr_drive),
        .o_chip_sel(chip_sel), .o_refresh_cmd(ref_cmd),
        .o_mode_set_cmd(mode_cmd), .o_mode_latency(lat),
        .i_access_req(req), .i_banks_precharged(prech),
        .i_refresh_due(due), .o_feedback_mem_clock(fb_clk),
        .o_mem_clk(mem_clk));

    sdram_model sdram_model_i (
        .i_clock(i_clock), .i_refresh_cmd(ref_cmd), .i_mode_set_cmd(mode_cmd),
        .i_mode_latency(lat), .i_busy(busy), .o_banks_precharged(prech),
        .i_fb_clk(fb_clk), .i_mem_clk(mem_clk), .o_n_ref(n_ref),
        .o_ref_gap(ref_gap), .o_n_mode(n_mode), .o_lat(m_lat),
        .o_clk_cnt(cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdw(input logic [15:0] a);
        @(posedge i_clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdw

    // msk bit k set means clock k should be held still
    task automatic clk_chk(input logic [4:0] msk);
        // masks need a few link clocks to cross before counting
        idle(12);
        snap = cnt;
        repeat (60) @(posedge i_clock);
        for (int k = 0; k < 5; k++) begin
            chk(cnt[k] != snap[k], !msk[k]);
        end
    endtask : clk_chk

    task automatic idle(input int n);
        repeat (n) @(posedge i_clock);
    endtask : idle

    // bound on the whole run; a hang lands in the same verdict
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        idle(4);
        i_sys_rst <= 1'b0;
        idle(2);
        rdw(16'h8404);
        chk(rd, 32'h00000801);
        clk_chk(5'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(rs, rows[i].resp);
            rdw(rows[i].a);
            chk(rd, rows[i].rexp);
            chk(rs, rows[i].resp);
        end
        wr(16'h8410, 32'h0); // status is read only
        chk(rs, 2'h2);
        wr(16'h8404, 32'h00000480);
        clk_chk(5'h12);
        wr(16'h8404, 32'h00000340);
        clk_chk(5'h0d);
        // refresh burst per stagger code: 1 command, else 4 spaced gap+1
        for (int c = 0; c < 4; c++) begin
            base = n_ref;
            wr(16'h8400, {24'h0, c[1:0], 6'h10});
            idle(40);
            chk(n_ref - base, (c == 0) ? 1 : 4);
            if (c > 0) chk(ref_gap, (c == 3) ? 5 : c + 1);
            wr(16'h8400, 32'h0);
        end
        // mode program waits for precharge, then once per rising edge
        wr(16'h8408, 32'h00000003);
        busy <= 1'b1;
        base = n_mode;
        wr(16'h8400, 32'h00000001);
        idle(10);
        chk(n_mode - base, 0);
        busy <= 1'b0;
        due <= 1'b1;
        idle(10);
        chk(n_mode - base, 0);
        due <= 1'b0;
        idle(10);
        chk(n_mode - base, 1);
        chk(m_lat, 3'h3);
        wr(16'h8400, 32'h00000001);
        idle(10);
        chk(n_mode - base, 1);
        wr(16'h8400, 32'h0);
        wr(16'h8400, 32'h00000001);
        idle(10);
        chk(n_mode - base, 2);
        // address setup: chip select one or two cycles after request
        for (int s = 0; s < 2; s++) begin
            wr(16'h8400, {26'h0, s[0], 5'h0});
            req <= 1'b1;
            #1 chk(addr_drive, 1'b0);
            idle(1);
            #1 chk({addr_drive, chip_sel}, s ? 2'b10 : 2'b11);
            idle(1);
            #1 chk(chip_sel, 1'b1);
            idle(1);
            req <= 1'b0;
            idle(1);
        end
        // remap only inside the window and only with the bit set
        for (int m = 0; m < 2; m++) begin
            wr(16'h8400, {29'h0, m[0], 2'h0});
            mem_addr <= 24'h400010;
            idle(2);
            #1 chk(o_mem_addr, m ? 24'h0a0010 : 24'h400010);
            idle(1);
            mem_addr <= 24'h41fff0;
            idle(2);
            #1 chk(o_mem_addr, m ? 24'h0bfff0 : 24'h41fff0);
            idle(1);
            mem_addr <= 24'h420000;
            idle(2);
            #1 chk(o_mem_addr, 24'h420000);
        end
        // arbitration: hp display always first, cpu first when fixed
        wr(16'h8400, 32'h0);
        wr(16'h840c, 32'h0000000f);
        rdw(16'h8410);
        chk(rd[3:1], 3'b000);
        wr(16'h840c, 32'h0000000e);
        rdw(16'h8410);
        chk(rd[3:2], 2'h1);
        wr(16'h8400, 32'h00000008);
        rdw(16'h8410);
        chk(rd[1], 1'b1);
        chk(rd[3:2] != 2'h0, 1'b1);
        wr(16'h840c, 32'h0000000f);
        rdw(16'h8410);
        chk(rd[3:2], 2'h0);
        // mid-run reset restores control two
        i_sys_rst <= 1'b1;
        idle(2);
        i_sys_rst <= 1'b0;
        idle(2);
        rdw(16'h8404);
        chk(rd, 32'h00000801);
        tally_and_finish();
    end
endmodule : sdram_ctrl_config_bits_test

`default_nettype wire
